/* osc_mode_pkg.sv */
// Constants shared by the oscillator and operating mode controller
package osc_mode_pkg;

	// Register port
	localparam int         REG_ADDR_W          = 8;
	localparam int         REG_DATA_W          = 8;
	localparam logic [7:0] OSC_MODE_CTRL_ADDR  = 8'hCA;
	localparam logic [7:0] OSC_MODE_CTRL_RESET = 8'h00;

	// Field positions of the control register
	localparam int STOP_BIT = 1;
	localparam int SLOW_BIT = 2;
	localparam int MODE_LSB = 3;
	localparam int MODE_MSB = 4;

	// CPU mode field codes
	localparam logic [1:0] CPU_MODE_NORMAL   = 2'h0;
	localparam logic [1:0] CPU_MODE_SLEEP    = 2'h1;
	localparam logic [1:0] CPU_MODE_GREEN    = 2'h2;
	localparam logic [1:0] CPU_MODE_RESERVED = 2'h3;

	// High clock code option
	localparam int         OPT_W          = 3;
	localparam logic [2:0] OPT_INT_8M     = 3'h0;
	localparam logic [2:0] OPT_INT_RTC    = 3'h1;
	localparam logic [2:0] OPT_EXT_RC     = 3'h2;
	localparam logic [2:0] OPT_XTAL_32K   = 3'h3;
	localparam logic [2:0] OPT_XTAL_12M   = 3'h4;
	localparam logic [2:0] OPT_XTAL_4M    = 3'h5;

	// Port inputs watched for level change
	localparam int PORT_W = 8;

	// Warm-up counts in high oscillator clocks
	localparam int          WARMUP_W            = 12;
	localparam logic [11:0] RESET_WARMUP_CLOCKS = 12'h800;
	localparam logic [11:0] XTAL_WAKE_CLOCKS    = 12'h800;
	localparam logic [11:0] RC_WAKE_CLOCKS      = 12'h020;

	// Slow mode instruction divider
	localparam int         SLOW_DIVIDE   = 4;
	localparam logic [1:0] SLOW_DIV_LAST = 2'h3;

endpackage : osc_mode_pkg

/* osc_bit_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module osc_bit_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_t;

	sync_state_t s_reg;
	sync_state_t s_next;

	always_comb begin
		s_next        = s_reg;
		s_next.meta   = async_in;
		s_next.stable = s_reg.meta;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_out = s_reg.stable;

endmodule : osc_bit_sync

/* osc_warmup_timer.sv */
// Counts oscillator ticks down from a loaded limit
`timescale 1ns/10ps
module osc_warmup_timer #(
	parameter int W = 12
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// Control
	input  wire logic         start,
	input  wire logic [W-1:0] limit,
	input  wire logic         tick,
	// Status
	output logic              busy
);

	typedef struct packed {
		logic [W-1:0] remaining;
		logic         busy;
	} warm_state_t;

	warm_state_t w_reg;
	warm_state_t w_next;

	always_comb begin
		w_next = w_reg;
		if (start) begin
			w_next.remaining = limit;
			w_next.busy      = 1'b1;
		end else if (w_reg.busy && tick) begin
			w_next.remaining = w_reg.remaining - {{(W-1){1'b0}}, 1'b1};
			if (w_reg.remaining <= {{(W-1){1'b0}}, 1'b1}) begin
				w_next.busy = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			w_reg <= '0;
		end else begin
			w_reg <= w_next;
		end
	end

	assign busy = w_reg.busy;

endmodule : osc_warmup_timer

/* oscillator_mode_controller.sv */
// Oscillator selection and operating mode controller
//
// Function
// R1: Slow mode instruction rate is the low RC clock divided by four.
// R2: Low RC stops only in power-down, or green with 32K option and watchdog off.
// R3: No control bit stops the low RC on its own.
// R4: Control register at 0CAH, bits 4..1 writable, others read zero, reset zero.
// R5: Bit 1 stops the high oscillator; the low RC keeps running.
// R6: Bit 2 selects high clock (normal) or low RC clock (slow).
// R7: Bits 4..3 are CPU mode: 00 normal, 01 sleep, 10 green, 11 reserved.
// R8: Stop bit disables internal 8M RC, RTC crystal too, or the external oscillator.
// R9: After any reset wait 2048 high oscillator clocks before running.
// R10: Power-down wake waits 2048 clocks for crystals, 32 for RC types.
// R11: Oscillator and instruction activity follow the operating mode table.
// R12: Green keeps only the basic timer; timer inactive in power-down. Code also keeps external interrupts active in green.
// R13: After reset release the device runs in normal mode on the high clock.
// R14: Entering slow mode never stops the high oscillator automatically.
// R15: Green wake returns to the mode held before entry, normal or slow.
// R16: Power-down always resumes in normal mode.
// R17: Power-down exits only on a port zero or port one level change.
// R18: Writing the sleep request enters power-down; hardware clears it on wake.
// R19: High oscillator stopped in normal mode halts like power-down until port change.
// R20: Writing the green request enters green; hardware clears it on wake.
// R21: Green wake applies no warm-up delay.
// R22: Reserved CPU mode code keeps normal operation.
// R23: Level change compares port levels with those sampled on low-power entry.
`timescale 1ns/10ps
module oscillator_mode_controller #(
	parameter logic [osc_mode_pkg::WARMUP_W-1:0] RESET_WARMUP = osc_mode_pkg::RESET_WARMUP_CLOCKS,
	parameter logic [osc_mode_pkg::WARMUP_W-1:0] XTAL_WAKE    = osc_mode_pkg::XTAL_WAKE_CLOCKS,
	parameter logic [osc_mode_pkg::WARMUP_W-1:0] RC_WAKE      = osc_mode_pkg::RC_WAKE_CLOCKS
) (
	// Clock and reset
	input  wire logic                                CORE_CLK,
	input  wire logic                                RESETN,
	// Register port
	input  wire logic [osc_mode_pkg::REG_ADDR_W-1:0] REG_ADDR,
	input  wire logic [osc_mode_pkg::REG_DATA_W-1:0] REG_WDATA,
	input  wire logic                                REG_WR,
	input  wire logic                                REG_RD,
	output logic      [osc_mode_pkg::REG_DATA_W-1:0] REG_RDATA,
	// Code options
	input  wire logic [osc_mode_pkg::OPT_W-1:0]      HIGH_CLK_OPTION,
	input  wire logic                                WATCHDOG_ENABLE,
	// Oscillator clocks observed as inputs
	input  wire logic                                HIGH_OSC_CLK,
	input  wire logic                                LOW_OSC_CLK,
	// Wake sources
	input  wire logic [osc_mode_pkg::PORT_W-1:0]     PORT_ZERO_IN,
	input  wire logic [osc_mode_pkg::PORT_W-1:0]     PORT_ONE_IN,
	input  wire logic                                BASIC_TIMER_ENABLE,
	input  wire logic                                BASIC_TIMER_OVERFLOW,
	// Oscillator enables
	output logic                                     INT_HIGH_RC_EN,
	output logic                                     RTC_XTAL_EN,
	output logic                                     EXT_HIGH_OSC_EN,
	output logic                                     LOW_RC_EN,
	// System clock and execution
	output logic                                     SYS_CLK_LOW,
	output logic                                     SLOW_CPU_TICK,
	output logic                                     CPU_RUN,
	output logic                                     WARMUP_BUSY,
	output logic                                     IN_GREEN,
	output logic                                     IN_POWER_DOWN,
	// Peripheral activity
	output logic                                     BASIC_TIMER_ACTIVE,
	output logic                                     INTERNAL_INT_ACTIVE,
	output logic                                     EXTERNAL_INT_ACTIVE
);
	import osc_mode_pkg::*;

	localparam int SYNC_W = 2 * PORT_W + 2;

	typedef enum logic [2:0] {
		ST_WARMUP,
		ST_RUN,
		ST_GREEN,
		ST_SLEEP,
		ST_HALT
	} fsm_t;

	typedef struct packed {
		fsm_t                  state;
		logic                  stop;
		logic                  slow;
		logic [1:0]            mode;
		logic [2*PORT_W-1:0]   snap;
		logic                  hi_q;
		logic                  lo_q;
		logic [1:0]            div;
		logic                  slow_tick;
		logic [REG_DATA_W-1:0] rdata;
		logic                  warm_start;
		logic [WARMUP_W-1:0]   warm_limit;
	} ctrl_state_t;

	ctrl_state_t r_reg;
	ctrl_state_t r_next;

	logic [SYNC_W-1:0]   sync_bus;
	logic [2*PORT_W-1:0] port_s;
	logic                hi_s;
	logic                lo_s;
	logic                hi_rise;
	logic                lo_rise;
	logic                port_change;
	logic                timer_wake;
	logic                rc_type;
	logic [WARMUP_W-1:0] wake_limit;
	logic                warm_busy;
	logic                high_on;
	logic                low_on;
	logic                int_high_opt;
	logic                hit;

	// Pins and oscillator clocks pass two flip-flops
	osc_bit_sync #(
		.W (SYNC_W)
	) u_sync (
		.clk      (CORE_CLK),
		.resetn   (RESETN),
		.async_in ({HIGH_OSC_CLK, LOW_OSC_CLK, PORT_ONE_IN, PORT_ZERO_IN}),
		.sync_out (sync_bus)
	);

	assign port_s  = sync_bus[2*PORT_W-1:0];
	assign lo_s    = sync_bus[2*PORT_W];
	assign hi_s    = sync_bus[2*PORT_W+1];
	assign hi_rise = hi_s && !r_reg.hi_q;
	assign lo_rise = lo_s && !r_reg.lo_q;

	// Warm-up counter on high oscillator edges
	osc_warmup_timer #(
		.W (WARMUP_W)
	) u_warm (
		.clk    (CORE_CLK),
		.resetn (RESETN),
		.start  (r_reg.warm_start),
		.limit  (r_reg.warm_limit),
		.tick   (hi_rise),
		.busy   (warm_busy)
	);

	// Wake detection
	assign port_change = (port_s != r_reg.snap); // R23 R17
	assign timer_wake  = BASIC_TIMER_ENABLE && BASIC_TIMER_OVERFLOW; // R12

	// Oscillator type selects the wake warm-up
	assign int_high_opt = (HIGH_CLK_OPTION == OPT_INT_8M) || (HIGH_CLK_OPTION == OPT_INT_RTC);
	assign rc_type      = int_high_opt || (HIGH_CLK_OPTION == OPT_EXT_RC);
	assign wake_limit   = rc_type ? RC_WAKE : XTAL_WAKE; // R10

	assign hit = (REG_ADDR == OSC_MODE_CTRL_ADDR);

	always_comb begin
		r_next            = r_reg;
		r_next.hi_q       = hi_s;
		r_next.lo_q       = lo_s;
		r_next.slow_tick  = 1'b0;
		r_next.warm_start = 1'b0;
		r_next.rdata      = '0;

		unique case (r_reg.state)
			ST_WARMUP: begin
				// Normal mode once the oscillator is stable
				if (!r_reg.warm_start && !warm_busy) begin
					r_next.state = ST_RUN; // R9 R10 R13
				end
			end
			ST_RUN: begin
				if (r_reg.mode == CPU_MODE_SLEEP) begin
					r_next.state = ST_SLEEP; // R18
					r_next.snap  = port_s; // R23
				end else if (r_reg.mode == CPU_MODE_GREEN) begin
					r_next.state = ST_GREEN; // R20
					r_next.snap  = port_s; // R23
				end else if (!r_reg.slow && r_reg.stop) begin
					r_next.state = ST_HALT; // R19
					r_next.snap  = port_s; // R23
				end
			end
			ST_GREEN: begin
				// Slow bit is untouched, so the prior mode resumes at once
				if (port_change || timer_wake) begin
					r_next.state = ST_RUN; // R15 R21
					r_next.mode  = CPU_MODE_NORMAL; // R20
				end
			end
			ST_SLEEP: begin
				if (port_change) begin
					r_next.state      = ST_WARMUP; // R17
					r_next.mode       = CPU_MODE_NORMAL; // R18
					r_next.slow       = 1'b0; // R16
					r_next.stop       = 1'b0; // R16
					r_next.warm_start = 1'b1; // R10
					r_next.warm_limit = wake_limit; // R10
				end
			end
			ST_HALT: begin
				if (port_change) begin
					r_next.state      = ST_WARMUP; // R19
					r_next.stop       = 1'b0; // R19
					r_next.warm_start = 1'b1;
					r_next.warm_limit = wake_limit; // R10
				end
			end
			default: begin
				r_next.state = ST_WARMUP;
			end
		endcase

		// Slow mode instruction divider on low RC edges
		if (r_reg.state == ST_RUN && r_reg.slow && lo_rise) begin
			r_next.div = r_reg.div + 2'h1; // R1
			if (r_reg.div == SLOW_DIV_LAST) begin
				r_next.slow_tick = 1'b1; // R1
			end
		end

		// Software write lands after any hardware clear
		if (REG_WR && hit) begin
			r_next.stop = REG_WDATA[STOP_BIT]; // R5 R14
			r_next.slow = REG_WDATA[SLOW_BIT]; // R6
			if (REG_WDATA[MODE_MSB:MODE_LSB] == CPU_MODE_RESERVED) begin
				r_next.mode = CPU_MODE_NORMAL; // R22
			end else begin
				r_next.mode = REG_WDATA[MODE_MSB:MODE_LSB]; // R7
			end
		end

		// Read data one cycle after the strobe
		if (REG_RD && hit) begin
			r_next.rdata                   = '0; // R4
			r_next.rdata[STOP_BIT]         = r_reg.stop;
			r_next.rdata[SLOW_BIT]         = r_reg.slow;
			r_next.rdata[MODE_MSB:MODE_LSB] = r_reg.mode;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			r_reg            <= '0;
			r_reg.state      <= ST_WARMUP; // R9
			r_reg.stop       <= OSC_MODE_CTRL_RESET[STOP_BIT]; // R4
			r_reg.slow       <= OSC_MODE_CTRL_RESET[SLOW_BIT];
			r_reg.mode       <= OSC_MODE_CTRL_RESET[MODE_MSB:MODE_LSB];
			r_reg.warm_start <= 1'b1;
			r_reg.warm_limit <= RESET_WARMUP; // R9
		end else begin
			r_reg <= r_next;
		end
	end

	// Oscillator enables by mode
	always_comb begin
		high_on = (r_reg.state == ST_WARMUP) ||
			(((r_reg.state == ST_RUN) || (r_reg.state == ST_GREEN)) && !r_reg.stop); // R5 R11
		low_on  = (r_reg.state != ST_SLEEP) &&
			!((r_reg.state == ST_GREEN) && (HIGH_CLK_OPTION == OPT_XTAL_32K) &&
			!WATCHDOG_ENABLE); // R2 R3
	end

	assign INT_HIGH_RC_EN  = high_on && int_high_opt; // R8
	assign RTC_XTAL_EN     = high_on && (HIGH_CLK_OPTION == OPT_INT_RTC); // R8
	assign EXT_HIGH_OSC_EN = high_on && !int_high_opt; // R8
	assign LOW_RC_EN       = low_on; // R11

	// Clock selection and execution
	assign SYS_CLK_LOW   = r_reg.slow && (r_reg.state != ST_WARMUP); // R6
	assign SLOW_CPU_TICK = r_reg.slow_tick;
	assign CPU_RUN       = (r_reg.state == ST_RUN); // R11
	assign WARMUP_BUSY   = (r_reg.state == ST_WARMUP);
	assign IN_GREEN      = (r_reg.state == ST_GREEN);
	assign IN_POWER_DOWN = (r_reg.state == ST_SLEEP) || (r_reg.state == ST_HALT);

	// Peripheral activity by mode
	assign BASIC_TIMER_ACTIVE  = BASIC_TIMER_ENABLE &&
		((r_reg.state == ST_RUN) || (r_reg.state == ST_GREEN)); // R12
	assign INTERNAL_INT_ACTIVE = (r_reg.state == ST_RUN); // R12
	assign EXTERNAL_INT_ACTIVE = (r_reg.state == ST_RUN) || (r_reg.state == ST_GREEN);

	assign REG_RDATA = r_reg.rdata;

	// Checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESETN);

	chk_low_rc_stop: assert property ( // R2
		!LOW_RC_EN |-> (r_reg.state == ST_SLEEP) ||
			((r_reg.state == ST_GREEN) && (HIGH_CLK_OPTION == OPT_XTAL_32K) &&
			!WATCHDOG_ENABLE))
		else $error("low RC stopped outside allowed modes");

	chk_sleep_entry: assert property ( // R18
		(r_reg.state == ST_RUN) && (r_reg.mode == CPU_MODE_SLEEP)
			|=> IN_POWER_DOWN && !CPU_RUN)
		else $error("sleep request did not enter power-down");

	chk_sleep_wake: assert property ( // R16
		(r_reg.state == ST_SLEEP) && port_change && !(REG_WR && hit)
			|=> WARMUP_BUSY && (r_reg.mode == CPU_MODE_NORMAL) && !r_reg.slow)
		else $error("power-down wake did not resume normal mode");

	chk_sleep_stays: assert property ( // R17
		(r_reg.state == ST_SLEEP) && !port_change |=> (r_reg.state == ST_SLEEP))
		else $error("power-down left without a port change");

	chk_green_wake: assert property ( // R21
		(r_reg.state == ST_GREEN) && (port_change || timer_wake) && !(REG_WR && hit)
			|=> CPU_RUN && (r_reg.slow == $past(r_reg.slow)) && !IN_GREEN)
		else $error("green wake delayed or mode lost");

	chk_high_stop: assert property ( // R5
		CPU_RUN && r_reg.stop |-> !INT_HIGH_RC_EN && !EXT_HIGH_OSC_EN && LOW_RC_EN)
		else $error("stop bit did not stop high oscillator");

	chk_slow_divide: assert property ( // R1
		SLOW_CPU_TICK |-> $past(lo_rise) && ($past(r_reg.div) == SLOW_DIV_LAST))
		else $error("slow tick not on fourth low RC edge");

	chk_reserved_code: assert property ( // R22
		CPU_RUN && (r_reg.mode == CPU_MODE_NORMAL) && REG_WR && hit &&
			(REG_WDATA[MODE_MSB:MODE_LSB] == CPU_MODE_RESERVED) &&
			(REG_WDATA[SLOW_BIT] || !REG_WDATA[STOP_BIT])
			|=> (r_reg.mode == CPU_MODE_NORMAL) ##1 !IN_GREEN && !IN_POWER_DOWN)
		else $error("reserved mode code left normal operation");

	chk_register_read: assert property ( // R4
		REG_RD && hit |=> (REG_RDATA[7:5] == 3'h0) && !REG_RDATA[0] &&
			(REG_RDATA[MODE_MSB:MODE_LSB] == $past(r_reg.mode)) &&
			(REG_RDATA[SLOW_BIT] == $past(r_reg.slow)))
		else $error("control register read wrong");

	chk_halt_entry: assert property ( // R19
		CPU_RUN && !r_reg.slow && r_reg.stop && (r_reg.mode == CPU_MODE_NORMAL)
			|=> IN_POWER_DOWN && !CPU_RUN)
		else $error("stopped high clock in normal mode did not halt");

	chk_warmup_hold: assert property ( // R9
		WARMUP_BUSY && warm_busy |=> WARMUP_BUSY && !CPU_RUN)
		else $error("left warm-up before the count ended");

	chk_timer_sleep: assert property ( // R12
		IN_POWER_DOWN |-> !BASIC_TIMER_ACTIVE && !INTERNAL_INT_ACTIVE && !EXTERNAL_INT_ACTIVE)
		else $error("timer or interrupts active in power-down");

endmodule : oscillator_mode_controller

/* tb.sv */
// Self-checking testbench of the oscillator and operating mode controller
`timescale 1ns/10ps
module tb;
	import osc_mode_pkg::*;

	localparam logic [11:0] RW = 12'h008;
	localparam logic [11:0] XW = 12'h010;
	localparam logic [11:0] CW = 12'h004;

	logic       CORE_CLK, RESETN, REG_WR, REG_RD, WATCHDOG_ENABLE;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, PORT_ZERO_IN, PORT_ONE_IN;
	logic [2:0] HIGH_CLK_OPTION;
	logic       HIGH_OSC_CLK, LOW_OSC_CLK, BASIC_TIMER_ENABLE, BASIC_TIMER_OVERFLOW;
	logic       INT_HIGH_RC_EN, RTC_XTAL_EN, EXT_HIGH_OSC_EN, LOW_RC_EN;
	logic       SYS_CLK_LOW, SLOW_CPU_TICK, CPU_RUN, WARMUP_BUSY, IN_GREEN, IN_POWER_DOWN;
	logic       BASIC_TIMER_ACTIVE, INTERNAL_INT_ACTIVE, EXTERNAL_INT_ACTIVE;
	logic [1:0] low_div;
	logic [31:0] lfsr;
	logic [7:0] d, m;
	int         errors, n_checks, cyc, ticks, n, wd;

	oscillator_mode_controller #(.RESET_WARMUP(RW), .XTAL_WAKE(XW), .RC_WAKE(CW)) u_dut (
		.CORE_CLK(CORE_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.HIGH_CLK_OPTION(HIGH_CLK_OPTION), .WATCHDOG_ENABLE(WATCHDOG_ENABLE),
		.HIGH_OSC_CLK(HIGH_OSC_CLK), .LOW_OSC_CLK(LOW_OSC_CLK),
		.PORT_ZERO_IN(PORT_ZERO_IN), .PORT_ONE_IN(PORT_ONE_IN),
		.BASIC_TIMER_ENABLE(BASIC_TIMER_ENABLE), .BASIC_TIMER_OVERFLOW(BASIC_TIMER_OVERFLOW),
		.INT_HIGH_RC_EN(INT_HIGH_RC_EN), .RTC_XTAL_EN(RTC_XTAL_EN),
		.EXT_HIGH_OSC_EN(EXT_HIGH_OSC_EN), .LOW_RC_EN(LOW_RC_EN), .SYS_CLK_LOW(SYS_CLK_LOW),
		.SLOW_CPU_TICK(SLOW_CPU_TICK), .CPU_RUN(CPU_RUN), .WARMUP_BUSY(WARMUP_BUSY),
		.IN_GREEN(IN_GREEN), .IN_POWER_DOWN(IN_POWER_DOWN),
		.BASIC_TIMER_ACTIVE(BASIC_TIMER_ACTIVE), .INTERNAL_INT_ACTIVE(INTERNAL_INT_ACTIVE),
		.EXTERNAL_INT_ACTIVE(EXTERNAL_INT_ACTIVE)
	);

	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	// Oscillator stand-ins, high rises every 2 cycles, low every 8
	always @(posedge CORE_CLK) begin
		HIGH_OSC_CLK <= ~HIGH_OSC_CLK;
		low_div <= low_div + 2'h1;
		if (low_div == 2'h3) begin
			LOW_OSC_CLK <= ~LOW_OSC_CLK;
		end
		if (SLOW_CPU_TICK === 1'b1) begin
			ticks <= ticks + 1;
		end
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors = errors + 1;
			conclude();
		end
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr_next

	// Stored image of a control write
	function automatic logic [7:0] reg_image(input logic [7:0] v);
		logic [7:0] r;
		r = v & 8'h1E;
		if (r[4:3] == 2'h3) begin
			r[4:3] = 2'h0;
		end
		return r;
	endfunction : reg_image

	task automatic conclude();
		if (errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rng(input int got, input int lo, input int hi);
		n_checks++;
		if (got < lo || got > hi) begin
			errors++;
			$display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask : rng

	task automatic step(input int k);
		repeat (k) @(posedge CORE_CLK);
		#1;
	endtask : step

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CORE_CLK);
		REG_ADDR  <= a;
		REG_WDATA <= v;
		REG_WR    <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1;
		chk(REG_RDATA, exp);
	endtask : rd

	// Cycles until instructions run again, bounded
	task automatic wait_run(output int k);
		k = 0;
		#1;
		while (CPU_RUN !== 1'b1 && k < 5000) begin
			@(posedge CORE_CLK);
			#1;
			k++;
		end
	endtask : wait_run

	initial begin
		{RESETN, REG_WR, REG_RD, BASIC_TIMER_OVERFLOW, HIGH_OSC_CLK, LOW_OSC_CLK} = 6'h0;
		{REG_ADDR, REG_WDATA, PORT_ZERO_IN, PORT_ONE_IN} = 32'h0;
		{HIGH_CLK_OPTION, WATCHDOG_ENABLE, BASIC_TIMER_ENABLE} = 5'h1;
		{low_div, errors, n_checks, cyc, ticks} = '0;
		lfsr = 32'h96EB;
		step(3);
		chk({WARMUP_BUSY, CPU_RUN, LOW_RC_EN}, 12'h5);
		step(2);
		@(posedge CORE_CLK);
		RESETN <= 1'b1;
		wait_run(n);
		rng(n, 2 * RW, 2 * RW + 12);
		chk({SYS_CLK_LOW, IN_POWER_DOWN, INTERNAL_INT_ACTIVE}, 12'h1);
		rd(OSC_MODE_CTRL_ADDR, OSC_MODE_CTRL_RESET);
		// Random and corner writes, no low-power entry
		for (int i = 0; i < 14; i++) begin
			lfsr = lfsr_next(lfsr);
			d = (i == 0) ? 8'hFF : (i == 1) ? 8'hE1 : lfsr[7:0];
			if (d[4:3] == 2'h1 || d[4:3] == 2'h2) begin
				d[4:3] = 2'h3;
			end
			d[1] = d[1] & d[2];
			wr(OSC_MODE_CTRL_ADDR, d);
			rd(OSC_MODE_CTRL_ADDR, reg_image(d));
			wr(8'hCB, ~d);
			rd(8'hCB, 8'h00);
			wait_run(n);
			chk({IN_POWER_DOWN, IN_GREEN}, 12'h0);
			chk(SYS_CLK_LOW, d[2]);
			chk({INT_HIGH_RC_EN, LOW_RC_EN}, {~d[1], 1'b1});
		end
		// Slow instruction rate
		wr(OSC_MODE_CTRL_ADDR, 8'h04);
		step(40);
		ticks = 0;
		step(320);
		rng(ticks, 9, 11);
		// Green from slow, timer wake
		wr(OSC_MODE_CTRL_ADDR, 8'h14);
		step(3);
		chk({IN_GREEN, CPU_RUN, BASIC_TIMER_ACTIVE}, 12'h5);
		chk({INTERNAL_INT_ACTIVE, EXTERNAL_INT_ACTIVE}, 12'h1);
		BASIC_TIMER_ENABLE <= 1'b0;
		BASIC_TIMER_OVERFLOW <= 1'b1;
		step(1);
		BASIC_TIMER_OVERFLOW <= 1'b0;
		step(4);
		chk(IN_GREEN, 1'b1);
		BASIC_TIMER_ENABLE <= 1'b1;
		BASIC_TIMER_OVERFLOW <= 1'b1;
		step(1);
		BASIC_TIMER_OVERFLOW <= 1'b0;
		wait_run(n);
		rng(n, 0, 4);
		rd(OSC_MODE_CTRL_ADDR, 8'h04);
		wr(OSC_MODE_CTRL_ADDR, 8'h00);
		wait_run(n);
		step(20);
		ticks = 0;
		step(100);
		chk(ticks, 0);
		// Stopped high clock in normal mode halts
		wr(OSC_MODE_CTRL_ADDR, 8'h02);
		step(3);
		chk({IN_POWER_DOWN, CPU_RUN}, 12'h2);
		PORT_ONE_IN <= PORT_ONE_IN ^ 8'h80;
		wait_run(n);
		rng(n, 2 * CW, 2 * CW + 12);
		rd(OSC_MODE_CTRL_ADDR, 8'h00);
		// Every high clock option through sleep, slow and green
		for (int o = 0; o < 6; o++) begin
			HIGH_CLK_OPTION <= 3'(o);
			step(2);
			wr(OSC_MODE_CTRL_ADDR, 8'h08);
			step(3);
			chk({IN_POWER_DOWN, CPU_RUN, LOW_RC_EN}, 12'h4);
			chk({INT_HIGH_RC_EN, RTC_XTAL_EN, EXT_HIGH_OSC_EN}, 12'h0);
			chk({BASIC_TIMER_ACTIVE, EXTERNAL_INT_ACTIVE}, 12'h0);
			BASIC_TIMER_OVERFLOW <= 1'b1;
			step(1);
			BASIC_TIMER_OVERFLOW <= 1'b0;
			step(6);
			chk({IN_POWER_DOWN, CPU_RUN}, 12'h2);
			lfsr = lfsr_next(lfsr);
			m = lfsr[7:0] | 8'h01;
			PORT_ZERO_IN <= PORT_ZERO_IN ^ m;
			wait_run(n);
			rng(n, (o <= 2) ? 2 * CW : 2 * XW, ((o <= 2) ? 2 * CW : 2 * XW) + 12);
			rd(OSC_MODE_CTRL_ADDR, 8'h00);
			chk({INT_HIGH_RC_EN, RTC_XTAL_EN, EXT_HIGH_OSC_EN}, {o <= 1, o == 1, o >= 2});
			wr(OSC_MODE_CTRL_ADDR, 8'h06);
			step(2);
			chk({INT_HIGH_RC_EN, RTC_XTAL_EN, EXT_HIGH_OSC_EN, LOW_RC_EN}, 12'h1);
			wr(OSC_MODE_CTRL_ADDR, 8'h00);
			wait_run(n);
			wd = (o == 3) ? 0 : int'(lfsr[8]);
			WATCHDOG_ENABLE <= wd[0];
			wr(OSC_MODE_CTRL_ADDR, 8'h10);
			step(3);
			chk({IN_GREEN, LOW_RC_EN}, {1'b1, !(o == 3 && wd == 0)});
			PORT_ONE_IN <= PORT_ONE_IN ^ m;
			wait_run(n);
			rng(n, 0, 6);
			rd(OSC_MODE_CTRL_ADDR, 8'h00);
		end
		// Reset in mid-run from slow mode with the high clock stopped
		wr(OSC_MODE_CTRL_ADDR, 8'h06);
		@(posedge CORE_CLK);
		RESETN <= 1'b0;
		step(2);
		chk({WARMUP_BUSY, CPU_RUN, SYS_CLK_LOW}, 12'h4);
		@(posedge CORE_CLK);
		RESETN <= 1'b1;
		wait_run(n);
		rng(n, 2 * RW, 2 * RW + 12);
		chk({SYS_CLK_LOW, EXT_HIGH_OSC_EN, CPU_RUN}, 12'h3);
		rd(OSC_MODE_CTRL_ADDR, OSC_MODE_CTRL_RESET);
		conclude();
	end
endmodule : tb
